/* verilog/lcd_port_pkg.sv */
/*
 * lcd_port_pkg: constants, command codes, register offsets and carrier types of the display
 * host port.
 * Assumes: used by lcd_host_port and its bench; register offsets are byte addresses on a 32-bit Wishbone bus.
 */
package lcd_port_pkg;

    // ************************************************************
    // geometry
    // ************************************************************
    localparam int COLS        = 256;
    localparam int PAGES       = 8;
    localparam int LINES       = 65;
    localparam int SEGS        = 224;
    localparam int COMS        = 64;
    localparam logic [3:0] IND_PAGE  = 4'h8;
    localparam logic [7:0] COL_LAST  = 8'hFF;
    localparam logic [6:0] LINE_LAST = 7'h40;

    // ************************************************************
    // wishbone register map
    // ************************************************************
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_OSC_DIV = 8'h08;
    localparam int CTRL_MASTER_BIT = 0;
    localparam int CTRL_OSC_BIT    = 1;
    localparam logic [1:0]  CTRL_RESET    = 2'h0;
    localparam logic [15:0] OSC_DIV_RESET = 16'h0010;

    // ************************************************************
    // host commands
    // ************************************************************
    localparam logic [7:0] CMD_DISP_OFF  = 8'hAE;
    localparam logic [7:0] CMD_DISP_ON   = 8'hAF;
    localparam logic [7:0] CMD_SEG_NORM  = 8'hA0;
    localparam logic [7:0] CMD_SEG_REV   = 8'hA1;
    localparam logic [7:0] CMD_ALL_OFF   = 8'hA4;
    localparam logic [7:0] CMD_ALL_ON    = 8'hA5;
    localparam logic [7:0] CMD_VID_NORM  = 8'hA6;
    localparam logic [7:0] CMD_VID_REV   = 8'hA7;
    localparam logic [7:0] CMD_OSC_ON    = 8'hAB;
    localparam logic [7:0] CMD_COM_NORM  = 8'hC0;
    localparam logic [7:0] CMD_COM_REV   = 8'hC8;
    localparam logic [1:0] CMD_LINE_TAG  = 2'h1;
    localparam logic [3:0] CMD_PAGE_TAG  = 4'hB;
    localparam logic [3:0] CMD_COLH_TAG  = 4'h1;
    localparam logic [3:0] CMD_COLL_TAG  = 4'h0;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic       valid;
        logic       is_data;
        logic [7:0] byte_v;
    } host_write_t;

    typedef struct packed {
        logic disp_on;
        logic seg_rev;
        logic com_rev;
        logic vid_rev;
        logic all_on;
        logic osc_on;
    } disp_mode_t;

endpackage : lcd_port_pkg

/* verilog/lcd_host_port.sv */
/*
 * lcd_host_port: host access path of a dot-matrix display driver: parallel 80/68 bus or
 * write-only serial entry, bus holder pipeline, busy flag, 65x256 display RAM, scan and latch.
 * Assumes: host pins and the display clock pin are asynchronous to MCLK; MCLK is much faster
 * than any host strobe or serial clock; a Wishbone classic master reaches the registers.
 */
`timescale 1ns/1ps

module lcd_host_port (
    input  wire logic                           MCLK,
    input  wire logic                           RESET,
    input  wire logic                           PARALLEL_SEL,
    input  wire logic                           BUS_STYLE_SELECT,
    input  wire logic                           SELECT_LOW_ACTIVE_N,
    input  wire logic                           SELECT_HIGH_ACTIVE,
    input  wire logic                           DATA_COMMAND_SELECT,
    input  wire logic                           STROBE_RD,
    input  wire logic                           STROBE_WR,
    input  wire logic [7:0]                     D_IN,
    output logic      [7:0]                     D_OUT,
    output logic      [7:0]                     D_OE,
    input  wire logic                           DISPLAY_CLOCK_PIN_IN,
    output logic                                DISPLAY_CLOCK_PIN_OUT,
    output logic                                DISPLAY_CLOCK_PIN_OE,
    output logic      [lcd_port_pkg::SEGS-1:0]  SEGMENT_OUT,
    output logic      [lcd_port_pkg::COMS:0]    COMMON_OUT,
    input  wire logic                           WB_CYC_I,
    input  wire logic                           WB_STB_I,
    input  wire logic                           WB_WE_I,
    input  wire logic [7:0]                     WB_ADR_I,
    input  wire logic [3:0]                     WB_SEL_I,
    input  wire logic [31:0]                    WB_DAT_I,
    output logic      [31:0]                    WB_DAT_O,
    output logic                                WB_ACK_O
);
    import lcd_port_pkg::*;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    localparam int PW = 16;
    logic [PW-1:0] pin_s1_r, pin_s2_r, pin_prev_r;
    logic          par, style68, sel, a0, rd, wr, clkpin;
    logic [7:0]    din;
    // no reset: stages refill from the pins during reset, so no false edge follows it
    always_ff @(posedge MCLK) begin
        pin_s1_r   <= {DISPLAY_CLOCK_PIN_IN, PARALLEL_SEL, BUS_STYLE_SELECT,
                       SELECT_LOW_ACTIVE_N, SELECT_HIGH_ACTIVE, DATA_COMMAND_SELECT,
                       STROBE_RD, STROBE_WR, D_IN};
        pin_s2_r   <= pin_s1_r;
        pin_prev_r <= pin_s2_r;
    end

    assign par     = pin_s2_r[14];
    assign style68 = pin_s2_r[13];
    assign sel     = !pin_s2_r[12] && pin_s2_r[11];
    assign a0      = pin_s2_r[10];
    assign rd      = pin_s2_r[9];
    assign wr      = pin_s2_r[8];
    assign din     = pin_s2_r[7:0];
    assign clkpin  = pin_s2_r[15] && !pin_prev_r[15];

    // ************************************************************
    // parallel cycle decode
    // ************************************************************
    logic rd_prev, wr_prev, rd_active, rd_end, wr_end;
    assign rd_prev = pin_prev_r[9];
    assign wr_prev = pin_prev_r[8];
    always_comb begin
        // strobe meaning follows the bus style pin
        if (style68) begin
            rd_active = rd && wr;
            rd_end    = !rd && rd_prev && wr;
            wr_end    = !rd && rd_prev && !wr;
        end else begin
            rd_active = !rd;
            rd_end    = rd && !rd_prev;
            wr_end    = wr && !wr_prev;
        end
    end

    // ************************************************************
    // serial entry (data on D7, clock on D6)
    // ************************************************************
    logic [7:0] shreg_r;
    logic [2:0] bitcnt_r;
    logic       scl_rise;
    assign scl_rise = pin_s2_r[6] && !pin_prev_r[6];
    always_ff @(posedge MCLK) begin
        if (RESET || !sel || par) begin
            shreg_r  <= '0;
            bitcnt_r <= '0;
        end else if (scl_rise) begin
            shreg_r  <= {shreg_r[6:0], pin_s2_r[7]};
            bitcnt_r <= bitcnt_r + 3'h1;
        end
    end

    // ************************************************************
    // unified write request
    // ************************************************************
    host_write_t req;
    logic        busy_r;
    logic        rd_data_evt;
    always_comb begin
        req = '0;
        if (sel && !busy_r) begin
            if (par) begin
                // select line splits data from command
                req.valid   = wr_end;
                req.is_data = a0;
                req.byte_v  = din;
            end else begin
                // select line taken at the same edge
                req.valid   = scl_rise && (bitcnt_r == 3'h7);
                req.is_data = a0;
                req.byte_v  = {shreg_r[6:0], pin_s2_r[7]};
            end
        end
    end
    assign rd_data_evt = sel && par && !busy_r && rd_end && a0;

    // ************************************************************
    // display RAM and address counters
    // ************************************************************
    logic [7:0]  mem [0:PAGES*COLS-1];
    logic        ind [0:COLS-1];
    logic [3:0]  page_r;
    logic [7:0]  col_r;
    logic [7:0]  holder_r;
    logic [7:0]  ram_rd;
    logic [10:0] wr_idx;
    disp_mode_t  mode_r;
    logic [5:0]  start_r;
    assign wr_idx = {page_r[2:0], col_r};
    // page and column select one byte
    // indicator page reads back bit zero only
    always_comb begin
        if (page_r == IND_PAGE) begin
            ram_rd = {7'h00, ind[col_r]};
        end else if (page_r[3]) begin
            ram_rd = 8'h00;
        end else begin
            ram_rd = mem[wr_idx];
        end
    end

    // holder committed one cycle after the write
    always_ff @(posedge MCLK) begin
        if (busy_r && !page_r[3]) begin
            mem[wr_idx] <= holder_r;
        end
        if (busy_r && page_r == IND_PAGE) begin
            ind[col_r] <= holder_r[0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= req.valid && req.is_data;
        end
    end

    // holder fetched by each data read, returned on the next
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            holder_r <= '0;
        end else if (req.valid && req.is_data) begin
            holder_r <= req.byte_v;
        end else if (rd_data_evt) begin
            holder_r <= ram_rd;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            col_r <= '0;
        end else if (req.valid && !req.is_data && req.byte_v[7:4] == CMD_COLH_TAG) begin
            col_r <= {req.byte_v[3:0], col_r[3:0]};
        end else if (req.valid && !req.is_data && req.byte_v[7:4] == CMD_COLL_TAG) begin
            col_r <= {col_r[7:4], req.byte_v[3:0]};
        end else if ((busy_r || rd_data_evt) && col_r != COL_LAST) begin
            col_r <= col_r + 8'h01;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            page_r <= '0;
        end else if (req.valid && !req.is_data && req.byte_v[7:4] == CMD_PAGE_TAG) begin
            page_r <= req.byte_v[3:0];
        end
    end

    // ************************************************************
    // command decode
    // ************************************************************
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            mode_r  <= '0;
            start_r <= '0;
        end else if (req.valid && !req.is_data) begin
            if (req.byte_v[7:6] == CMD_LINE_TAG) begin
                start_r <= req.byte_v[5:0];
            end
            unique case (req.byte_v)
                CMD_DISP_OFF: mode_r.disp_on <= 1'b0;
                CMD_DISP_ON:  mode_r.disp_on <= 1'b1;
                CMD_SEG_NORM: mode_r.seg_rev <= 1'b0;
                CMD_SEG_REV:  mode_r.seg_rev <= 1'b1;
                CMD_ALL_OFF:  mode_r.all_on  <= 1'b0;
                CMD_ALL_ON:   mode_r.all_on  <= 1'b1;
                CMD_VID_NORM: mode_r.vid_rev <= 1'b0;
                CMD_VID_REV:  mode_r.vid_rev <= 1'b1;
                CMD_OSC_ON:   mode_r.osc_on  <= 1'b1;
                CMD_COM_NORM: mode_r.com_rev <= 1'b0;
                CMD_COM_REV:  mode_r.com_rev <= 1'b1;
                default: ;
            endcase
        end
    end

    // ************************************************************
    // data pins
    // ************************************************************
    always_ff @(posedge MCLK) begin
        // serial mode never drives the pins
        if (!RESET && sel && par && rd_active) begin
            D_OUT <= a0 ? holder_r : {busy_r, mode_r.seg_rev, !mode_r.disp_on, 5'h00};
            D_OE  <= 8'hFF;
        end else begin
            D_OUT <= '0;
            D_OE  <= '0;
        end
    end

    // ************************************************************
    // wishbone registers
    // ************************************************************
    logic [1:0]  ctrl_r;
    logic [15:0] osc_div_r;
    logic        wb_hit;
    assign wb_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            WB_ACK_O  <= 1'b0;
            WB_DAT_O  <= '0;
            ctrl_r    <= CTRL_RESET;
            osc_div_r <= OSC_DIV_RESET;
        end else begin
            WB_ACK_O <= wb_hit;
            WB_DAT_O <= '0;
            if (wb_hit && WB_WE_I && WB_SEL_I[0]) begin
                if (WB_ADR_I == REG_CTRL) begin
                    ctrl_r <= WB_DAT_I[1:0];
                end
                if (WB_ADR_I == REG_OSC_DIV) begin
                    osc_div_r[7:0] <= WB_DAT_I[7:0];
                end
            end
            if (wb_hit && WB_WE_I && WB_SEL_I[1] && WB_ADR_I == REG_OSC_DIV) begin
                osc_div_r[15:8] <= WB_DAT_I[15:8];
            end
            if (wb_hit && !WB_WE_I) begin
                unique case (WB_ADR_I)
                    REG_CTRL:    WB_DAT_O <= {30'h0, ctrl_r};
                    REG_STATUS:  WB_DAT_O <= {2'h0, mode_r, start_r, page_r, col_r,
                                              5'h00, busy_r};
                    REG_OSC_DIV: WB_DAT_O <= {16'h0, osc_div_r};
                    default:     WB_DAT_O <= '0;
                endcase
            end
        end
    end

    // ************************************************************
    // display clock source
    // ************************************************************
    logic        osc_run, disp_tick;
    logic [15:0] osc_cnt_r;
    // oscillator only in master with oscillator select after the on command
    assign osc_run = ctrl_r[CTRL_MASTER_BIT] && ctrl_r[CTRL_OSC_BIT] && mode_r.osc_on;
    always_ff @(posedge MCLK) begin
        if (RESET || !osc_run) begin
            osc_cnt_r             <= '0;
            DISPLAY_CLOCK_PIN_OUT <= 1'b0;
        end else if (osc_cnt_r >= osc_div_r) begin
            osc_cnt_r             <= '0;
            DISPLAY_CLOCK_PIN_OUT <= !DISPLAY_CLOCK_PIN_OUT;
        end else begin
            osc_cnt_r <= osc_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            DISPLAY_CLOCK_PIN_OE <= 1'b0;
        end else begin
            DISPLAY_CLOCK_PIN_OE <= ctrl_r[CTRL_MASTER_BIT] && ctrl_r[CTRL_OSC_BIT];
        end
    end

    // ticks on each divider wrap that raises the clock out, or on display clock pin rise with oscillator select clear
    assign disp_tick = osc_run ? (osc_cnt_r >= osc_div_r && !DISPLAY_CLOCK_PIN_OUT)
                               : (!ctrl_r[CTRL_OSC_BIT] && clkpin);

    // ************************************************************
    // line scan and display latch
    // ************************************************************
    logic [6:0]      scan_r;
    logic [6:0]      row;
    logic [7:0]      row_sum;
    logic [SEGS-1:0] seg_nxt;
    logic [COMS:0]   com_nxt;
    // rows follow the start line modulo 65
    always_comb begin
        row_sum = {2'h0, start_r} + {1'b0, scan_r};
        row     = (row_sum >= 8'(LINES)) ? 7'(row_sum - 8'(LINES)) : row_sum[6:0];
    end

    always_comb begin
        logic [7:0] c;
        logic       b;
        c = '0;
        b = 1'b0;
        for (int s = 0; s < SEGS; s++) begin
            c = mode_r.seg_rev ? 8'(COL_LAST - 8'(s)) : 8'(s);
            b = (row == LINE_LAST) ? ind[c] : mem[{row[5:3], c}][row[2:0]];
            seg_nxt[s] = mode_r.disp_on && (mode_r.all_on || (b ^ mode_r.vid_rev));
        end
    end

    // scan zero lands on first or last common
    always_comb begin
        com_nxt = '0;
        if (scan_r == LINE_LAST) begin
            com_nxt[COMS] = mode_r.disp_on;
        end else if (mode_r.com_rev) begin
            com_nxt[6'(COMS - 1) - scan_r[5:0]] = mode_r.disp_on;
        end else begin
            com_nxt[scan_r[5:0]] = mode_r.disp_on;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            scan_r      <= '0;
            SEGMENT_OUT <= '0;
            COMMON_OUT  <= '0;
        end else if (disp_tick) begin
            scan_r      <= (scan_r == LINE_LAST) ? 7'h00 : scan_r + 7'h01;
            SEGMENT_OUT <= seg_nxt;
            COMMON_OUT  <= com_nxt;
        end
    end

endmodule : lcd_host_port

/* bench/lcd_host_port_sva.sv */
/* lcd_host_port_sva: assertions on the host port pins and the register bus.
   Assumes: bound to lcd_host_port; one clock MCLK with synchronous RESET. */
`timescale 1ns/1ps
module lcd_host_port_sva (
    input wire logic                        MCLK,
    input wire logic                        RESET,
    input wire logic                        PARALLEL_SEL,
    input wire logic                        SELECT_LOW_ACTIVE_N,
    input wire logic                        SELECT_HIGH_ACTIVE,
    input wire logic [7:0]                  D_OE,
    input wire logic                        DISPLAY_CLOCK_PIN_OUT,
    input wire logic                        DISPLAY_CLOCK_PIN_OE,
    input wire logic [lcd_port_pkg::COMS:0] COMMON_OUT,
    input wire logic                        WB_CYC_I,
    input wire logic                        WB_STB_I,
    input wire logic                        WB_ACK_O
);
    import lcd_port_pkg::*;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    a_float_desel: assert property (
        (SELECT_LOW_ACTIVE_N || !SELECT_HIGH_ACTIVE) [*6] |-> D_OE == 8'h00)
        else $error("pins driven while deselected");
    a_serial_quiet: assert property (
        (!PARALLEL_SEL) [*6] |-> D_OE == 8'h00) else $error("pins driven in serial mode");
    a_oe_whole: assert property (D_OE == 8'h00 || D_OE == 8'hFF)
        else $error("partial data enable");
    a_osc_gated: assert property (
        !DISPLAY_CLOCK_PIN_OE && !$past(DISPLAY_CLOCK_PIN_OE) |-> $stable(DISPLAY_CLOCK_PIN_OUT))
        else $error("oscillator runs while disabled");
    a_com_onehot: assert property ($onehot0(COMMON_OUT))
        else $error("more than one common active");
    a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("bus request not acknowledged");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
    a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_STB_I) && $past(WB_CYC_I))
        else $error("ack without request");
endmodule : lcd_host_port_sva
bind lcd_host_port lcd_host_port_sva lcd_host_port_sva_i (.MCLK(MCLK), .RESET(RESET),
    .PARALLEL_SEL(PARALLEL_SEL), .SELECT_LOW_ACTIVE_N(SELECT_LOW_ACTIVE_N),
    .SELECT_HIGH_ACTIVE(SELECT_HIGH_ACTIVE), .D_OE(D_OE),
    .DISPLAY_CLOCK_PIN_OUT(DISPLAY_CLOCK_PIN_OUT), .DISPLAY_CLOCK_PIN_OE(DISPLAY_CLOCK_PIN_OE),
    .COMMON_OUT(COMMON_OUT), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O));

/* bench/mpu_model.sv */
/* mpu_model: host processor on the display port pins, 80/68 parallel or serial.
   Assumes: the bench spaces calls; released data lines show the inverse of the last parallel value, or of the last serial bit on D7. */
`timescale 1ns/1ps
module mpu_model (
    input  wire logic       MCLK,
    input  wire logic       style68,
    output logic            sel_n,
    output logic            sel_h,
    output logic            a0,
    output logic            rd,
    output logic            wr,
    output logic [7:0]      d
);
    initial {sel_n, sel_h, a0, rd, wr, d} = 13'h1300;
    task automatic xfer(input logic a, input logic r, input logic [7:0] v, input logic cs);
        @(posedge MCLK);
        rd <= !style68;
        wr <= 1'h1;
        repeat (4) @(posedge MCLK);
        {sel_n, sel_h} <= {!cs, cs};
        a0 <= a;
        d <= v;
        rd <= style68 || !r;
        wr <= r;
        repeat (8) @(posedge MCLK);
        rd <= !style68;
        wr <= style68 ? r : 1'h1;
        repeat (5) @(posedge MCLK);
        {sel_n, sel_h} <= 2'h2;
        d <= ~v;
        repeat (4) @(posedge MCLK);
    endtask : xfer
    // msb first, select line held over the byte, clock idles low
    task automatic ser(input logic a, input logic [7:0] v, input int n);
        @(posedge MCLK);
        {sel_n, sel_h} <= 2'h1;
        a0 <= a;
        for (int i = 7; i > 7 - n; i--) begin
            d <= {v[i], 7'h00};
            repeat (6) @(posedge MCLK);
            d[6] <= 1'h1;
            repeat (7) @(posedge MCLK);
        end
        d <= {~d[7], 7'h00};
        repeat (6) @(posedge MCLK);
        {sel_n, sel_h} <= 2'h2;
        repeat (4) @(posedge MCLK);
    endtask : ser
endmodule : mpu_model

/* bench/test_lcd_host_port.sv */
/* test_lcd_host_port: self-checking bench of the display host port.
   Assumes: package, design, mpu_model and checker are compiled before it. */
`timescale 1ns/1ps
module test_lcd_host_port;
    import lcd_port_pkg::*;
    localparam logic [31:0] SM = 32'h0003_FFC0;
    logic          clk = 1'h0;
    logic          rst = 1'h1;
    logic          psel = 1'h1;
    logic          style = 1'h0;
    logic          lclk = 1'h0;
    logic          cyc = 1'h0;
    logic          stb = 1'h0;
    logic          wem = 1'h0;
    logic          oe_was = 1'h0;
    logic [7:0]    adr = 8'h00;
    logic [31:0]   wdat = 32'h0;
    logic          sn, sh, a0, rd, wr, ack, cko, ckoe;
    logic [7:0]    d, dout, doe, b [3], pq [$], pm [$];
    logic [31:0]   rdat, wq [$], wm [$];
    logic [COMS:0] com;
    logic [7:0]    nc [5] = '{CMD_SEG_NORM, CMD_COM_NORM, CMD_VID_NORM, CMD_ALL_OFF, CMD_DISP_OFF};
    int            bad_count = 0;
    int            comparisons = 0;
    int            cycles = 0;
    always #2.5 clk = ~clk;
    always #32 lclk = ~lclk;
    lcd_host_port lcd_host_port_i (.MCLK(clk), .RESET(rst), .PARALLEL_SEL(psel),
        .BUS_STYLE_SELECT(style), .SELECT_LOW_ACTIVE_N(sn), .SELECT_HIGH_ACTIVE(sh),
        .DATA_COMMAND_SELECT(a0), .STROBE_RD(rd), .STROBE_WR(wr), .D_IN((doe & dout) | (~doe & d)),
        .D_OUT(dout), .D_OE(doe), .DISPLAY_CLOCK_PIN_IN(ckoe ? cko : lclk),
        .DISPLAY_CLOCK_PIN_OUT(cko), .DISPLAY_CLOCK_PIN_OE(ckoe), .SEGMENT_OUT(),
        .COMMON_OUT(com), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(wem), .WB_ADR_I(adr),
        .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack));
    mpu_model mpu_model_i (.MCLK(clk), .style68(style), .sel_n(sn), .sel_h(sh), .a0(a0),
        .rd(rd), .wr(wr), .d(d));
    task automatic results;
        bad_count += pq.size() + wq.size();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    task automatic cmp_wb(input logic [31:0] e, m, g);
        comparisons++;
        if ((g & m) !== e) begin
            bad_count++;
            $display("ERROR %0t bus read %h expected %h", $time, g & m, e);
        end
    endtask : cmp_wb
    task automatic cmp_pin(input logic [7:0] e, m, g);
        comparisons++;
        if ((g & m) !== e) begin
            bad_count++;
            $display("ERROR %0t pin read %h expected %h", $time, g & m, e);
        end
    endtask : cmp_pin
    // results are matched against the oldest note as they appear
    always @(posedge clk) begin
        if (ack === 1'h1 && wem === 1'h0 && wq.size() > 0) cmp_wb(wq.pop_front(), wm.pop_front(), rdat);
        if (doe === 8'hFF && !oe_was && pq.size() > 0) cmp_pin(pq.pop_front(), pm.pop_front(), dout);
        oe_was <= (doe === 8'hFF);
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end
    task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] v, e, m);
        @(posedge clk);
        {cyc, stb, wem, adr, wdat} <= {2'h3, w, a, v};
        if (!w) wq.push_back(e);
        if (!w) wm.push_back(m);
        do @(posedge clk); while (ack !== 1'h1);
        {cyc, stb} <= 2'h0;
    endtask : wbx
    task automatic cmd(input logic [7:0] v); mpu_model_i.xfer(1'h0, 1'h0, v, 1'h1); endtask : cmd
    task automatic dw(input logic [7:0] v); mpu_model_i.xfer(1'h1, 1'h0, v, 1'h1); endtask : dw
    task automatic prd(input logic a, input logic [7:0] e, m);
        pq.push_back(e);
        pm.push_back(m);
        mpu_model_i.xfer(a, 1'h1, 8'h00, 1'h1);
    endtask : prd
    task automatic setad(input logic [3:0] p, input logic [7:0] c);
        cmd({CMD_PAGE_TAG, p});
        cmd({CMD_COLH_TAG, c[7:4]});
        cmd({CMD_COLL_TAG, c[3:0]});
    endtask : setad
    task automatic rback(input logic [3:0] p, input logic [7:0] c, input int n);
        setad(p, c);
        prd(1'h1, 8'h00, 8'h00);
        for (int k = 0; k < n; k++) prd(1'h1, b[k], 8'hFF);
    endtask : rback
    function automatic logic [31:0] st(input logic [3:0] p, input logic [7:0] c);
        return {14'h0, p, c, 6'h00};
    endfunction : st
    initial begin
        void'($urandom(32'h6B4E26E7));
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        repeat (4) @(posedge clk);
        wbx(0, REG_CTRL, 0, {30'h0, CTRL_RESET}, 32'h3);
        wbx(0, REG_OSC_DIV, 0, {16'h0, OSC_DIV_RESET}, 32'hFFFF);
        wbx(0, 8'h40, 0, 32'h0, 32'hFFFFFFFF);
        prd(1'h0, 8'h20, 8'hFF);
        for (int s = 0; s < 2; s++) begin
            style <= s[0];
            setad(4'h2, 8'h10);
            foreach (b[k]) b[k] = 8'($urandom());
            foreach (b[k]) dw(b[k]);
            wbx(0, REG_STATUS, 0, st(4'h2, 8'h13), SM);
            rback(4'h2, 8'h10, 3);
            wbx(0, REG_STATUS, 0, st(4'h2, 8'h14), SM);
        end
        foreach (nc[i]) cmd(nc[i] == CMD_COM_NORM ? CMD_COM_REV : nc[i] ^ 8'h01);
        cmd({CMD_LINE_TAG, 6'h05});
        prd(1'h0, 8'h40, 8'hFF);
        wbx(0, REG_STATUS, 0, 32'h3E14_0000, 32'h3FFC_0000);
        rback(4'h2, 8'h10, 3);
        setad(4'h3, 8'hFE);
        foreach (b[k]) dw(b[k]);
        wbx(0, REG_STATUS, 0, st(4'h3, 8'hFF), SM);
        b[0] = b[2];
        b[1] = b[2];
        rback(4'h3, 8'hFF, 2);
        setad(4'h8, 8'h00);
        dw(8'hFF);
        b[0] = 8'h01;
        rback(4'h8, 8'h00, 1);
        mpu_model_i.xfer(1'h1, 1'h0, 8'hAA, 1'h0);
        mpu_model_i.xfer(1'h1, 1'h1, 8'h00, 1'h0);
        wbx(0, REG_STATUS, 0, st(4'h8, 8'h02), SM);
        foreach (nc[i]) cmd(nc[i]);
        wbx(1, REG_CTRL, 32'h3, 0, 0);
        wbx(1, REG_OSC_DIV, 32'h1, 0, 0);
        cmd(CMD_OSC_ON);
        cmd(CMD_DISP_ON);
        wbx(0, REG_STATUS, 0, 32'h2100_0000, 32'h3F00_0000);
        repeat (300) @(posedge clk);
        cmp_wb(32'h1, 32'h1, {31'h0, $onehot(com)});
        psel <= 1'h0;
        mpu_model_i.xfer(1'h1, 1'h1, 8'h40, 1'h1);
        mpu_model_i.ser(1'h0, 8'hB5, 3);
        mpu_model_i.ser(1'h0, {CMD_PAGE_TAG, 4'h5}, 8);
        mpu_model_i.ser(1'h0, 8'h12, 8);
        mpu_model_i.ser(1'h0, 8'h03, 8);
        mpu_model_i.ser(1'h1, b[2], 8);
        wbx(0, REG_STATUS, 0, st(4'h5, 8'h24), SM);
        psel <= 1'h1;
        b[0] = b[2];
        rback(4'h5, 8'h23, 1);
        results();
    end
endmodule : test_lcd_host_port
